// file: rtl/bnv_pkg.sv
// Notes on behaviour
// - The controller holds chip select high for at least the minimum recovery time between cycles.
// - The controller never holds chip select low beyond the longest allowed low time.
// - The controller gives every single access its own falling edge of chip select.
// - The controller never starts a new access by changing the address alone.
// - The controller takes no request while the supply is out of tolerance; an access already taken runs to its end regardless.
// - The controller keeps chip select low for at least 120 ns and at most 2,000 ns.
package bnv_pkg;
    // ****************************************
    // Clock and pin timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int SELECT_MIN_NS = 120;
    localparam int SELECT_MAX_NS = 2000;
    localparam int ACCESS_NS = 120;
    localparam int RECOVERY_NS = 60;
    localparam int STROBE_MIN_NS = 40;
    localparam int HZ_NS = 15;
    // Least times round up, longest times round down
    localparam int SELECT_MIN_CYC = (SELECT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SELECT_MAX_CYC = SELECT_MAX_NS / CLK_PERIOD_NS;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int RECOVERY_CYC = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_MIN_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HZ_CYC = (HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    // ****************************************
    // Geometry
    // ****************************************
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int ROW_BYTES = 4;
    localparam int ROW_LSB = 2;
    // ****************************************
    // Cycle sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        BNV_IDLE,
        BNV_SETUP,
        BNV_ACCESS,
        BNV_FINISH,
        BNV_RECOVER
    } bnv_state_t;
endpackage

// file: rtl/bnv_timer_if.sv
`timescale 1ns/100ps
`default_nettype none
// Load and status of the phase timer
interface bnv_timer_if;
    logic load;
    logic [bnv_pkg::CNT_W-1:0] value;
    logic done;
    modport owner (output load, output value, input done);
    modport timer (input load, input value, output done);
endinterface
`default_nettype wire

// file: rtl/bnv_timer.sv
`timescale 1ns/100ps
`default_nettype none
// Down counter that times the access and precharge phases of a bus cycle
module bnv_timer (
    input wire logic clock,
    input wire logic resetn,
    bnv_timer_if.timer tif
);
    logic [bnv_pkg::CNT_W-1:0] count;
    logic [bnv_pkg::CNT_W-1:0] next_count;

    // ****************************************
    // Counter
    // ****************************************
    // Load wins, else count down to zero
    always_comb begin
        next_count = count;
        if (tif.load) begin
            next_count = tif.value;
        end else if (count != '0) begin
            next_count = count - 8'h01;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count <= 8'h00;
        end else begin
            count <= next_count;
        end
    end

    assign tif.done = (count == '0) && !tif.load;
endmodule
`default_nettype wire

// file: rtl/bnv_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Controller that runs one strobed cycle per request on the memory pins
module bnv_ctrl #(
    parameter int ADDR_W = bnv_pkg::ADDR_W,
    parameter int DATA_W = bnv_pkg::DATA_W
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic supply_ok,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic mem_sel_n,
    output logic mem_wr_n,
    output logic mem_oe_n,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [DATA_W-1:0] bidir_data_bus_o,
    output logic bidir_data_bus_oe,
    input wire logic [DATA_W-1:0] bidir_data_bus_i
);
    bnv_pkg::bnv_state_t state, next_state;
    logic is_write, next_is_write;
    logic next_req_ready, next_rsp_valid;
    logic [DATA_W-1:0] next_rsp_rdata, next_dout;
    logic next_sel_n, next_wr_n, next_oe_n, next_doe;
    logic [ADDR_W-1:0] next_addr;
    logic [bnv_pkg::CNT_W-1:0] sel_low, next_sel_low;
    bnv_timer_if tif ();

    bnv_timer u_bnv_timer (
        .clock(clock),
        .resetn(resetn),
        .tif(tif)
    );

    // ****************************************
    // Cycle sequencer
    // ****************************************
    // Next pin, timer and handshake values
    always_comb begin
        next_state = state;
        next_is_write = is_write;
        next_req_ready = 1'b0;
        next_rsp_valid = 1'b0;
        next_rsp_rdata = rsp_rdata;
        next_sel_n = mem_sel_n;
        next_wr_n = mem_wr_n;
        next_oe_n = mem_oe_n;
        next_doe = bidir_data_bus_oe;
        next_dout = bidir_data_bus_o;
        next_addr = mem_addr;
        next_sel_low = mem_sel_n ? 8'h00 : sel_low + 8'h01;
        tif.load = 1'b0;
        tif.value = '0;
        unique case (state)
            bnv_pkg::BNV_IDLE: begin
                // No access while supply is out of tolerance
                if (req_valid && req_ready && supply_ok) begin
                    next_state = bnv_pkg::BNV_SETUP;
                    next_is_write = req_write;
                    next_addr = req_addr;
                    next_dout = req_wdata;
                end else begin
                    next_req_ready = supply_ok;
                end
            end
            bnv_pkg::BNV_SETUP: begin
                // Fresh falling edge per access, write strobe set on the same edge
                next_sel_n = 1'b0;
                next_wr_n = !is_write;
                next_doe = is_write;
                next_oe_n = is_write;
                tif.load = 1'b1;
                tif.value = 8'(bnv_pkg::SELECT_MIN_CYC - 1);
                next_state = bnv_pkg::BNV_ACCESS;
            end
            bnv_pkg::BNV_ACCESS: begin
                // Hold select low the least active time
                if (tif.done) begin
                    next_state = bnv_pkg::BNV_FINISH;
                end
            end
            bnv_pkg::BNV_FINISH: begin
                // Raise select; strobe rises with it
                next_sel_n = 1'b1;
                next_wr_n = 1'b1;
                next_oe_n = 1'b1;
                next_doe = 1'b0;
                if (!is_write) begin
                    next_rsp_rdata = bidir_data_bus_i;
                end
                next_rsp_valid = 1'b1;
                tif.load = 1'b1;
                tif.value = 8'(bnv_pkg::RECOVERY_CYC - 1);
                next_state = bnv_pkg::BNV_RECOVER;
            end
            bnv_pkg::BNV_RECOVER: begin
                // Precharge time before next falling edge
                if (tif.done) begin
                    next_state = bnv_pkg::BNV_IDLE;
                    next_req_ready = supply_ok;
                end
            end
            default: begin
                next_state = bnv_pkg::BNV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= bnv_pkg::BNV_IDLE;
            is_write <= 1'b0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            mem_sel_n <= 1'b1;
            mem_wr_n <= 1'b1;
            mem_oe_n <= 1'b1;
            mem_addr <= '0;
            bidir_data_bus_o <= '0;
            bidir_data_bus_oe <= 1'b0;
            sel_low <= 8'h00;
        end else begin
            state <= next_state;
            is_write <= next_is_write;
            req_ready <= next_req_ready;
            rsp_valid <= next_rsp_valid;
            rsp_rdata <= next_rsp_rdata;
            mem_sel_n <= next_sel_n;
            mem_wr_n <= next_wr_n;
            mem_oe_n <= next_oe_n;
            mem_addr <= next_addr;
            bidir_data_bus_o <= next_dout;
            bidir_data_bus_oe <= next_doe;
            sel_low <= next_sel_low;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    // Request taken and select edges
    sequence s_take;
        req_valid && req_ready && supply_ok;
    endsequence
    sequence s_sel_fall;
        $fell(mem_sel_n);
    endsequence
    sequence s_sel_rise;
        $rose(mem_sel_n);
    endsequence

    // Select low and high times
    a_select_low_min: assert property (@(posedge clock) disable iff (!resetn)
        s_sel_rise |-> (sel_low >= 8'(bnv_pkg::SELECT_MIN_CYC)))
        else $error("select low time too short");
    a_access_elapsed: assert property (@(posedge clock) disable iff (!resetn)
        s_sel_rise |-> (sel_low >= 8'(bnv_pkg::ACCESS_CYC)))
        else $error("data sampled before access time");
    a_select_low_max: assert property (@(posedge clock) disable iff (!resetn)
        sel_low <= 8'(bnv_pkg::SELECT_MAX_CYC))
        else $error("select held low too long");
    a_recovery_high: assert property (@(posedge clock) disable iff (!resetn)
        s_sel_rise |-> mem_sel_n [*8])
        else $error("precharge too short");
    // Pins at and inside the select window
    a_address_stable: assert property (@(posedge clock) disable iff (!resetn)
        !mem_sel_n |-> $stable(mem_addr))
        else $error("address moved while selected");
    a_write_early: assert property (@(posedge clock) disable iff (!resetn)
        s_sel_fall |-> (mem_wr_n == !is_write))
        else $error("write strobe not set at select edge");
    a_strobe_ends: assert property (@(posedge clock) disable iff (!resetn)
        s_sel_rise |-> mem_wr_n && !bidir_data_bus_oe)
        else $error("write strobe outlived select");
    a_no_contend: assert property (@(posedge clock) disable iff (!resetn)
        bidir_data_bus_oe |-> mem_oe_n)
        else $error("bus contention");
    a_response_one: assert property (@(posedge clock) disable iff (!resetn)
        s_sel_rise |-> rsp_valid ##1 !rsp_valid)
        else $error("missing response");
    a_supply_gate: assert property (@(posedge clock) disable iff (!resetn)
        s_sel_fall |-> $past(supply_ok, 2))
        else $error("access with bad supply");

    // ****************************************
    // Handshake checks
    // ****************************************
    // Every taken request gets its own select edge
    a_take_strobes: assert property (@(posedge clock) disable iff (!resetn)
        s_take |-> ##2 s_sel_fall)
        else $error("taken request without select edge");
    a_fall_needs_take: assert property (@(posedge clock) disable iff (!resetn)
        s_sel_fall |-> $past(req_valid && req_ready, 2))
        else $error("select edge without request");
    a_one_take: assert property (@(posedge clock) disable iff (!resetn)
        s_take |=> !req_ready)
        else $error("ready stayed high after take");
    // Ready held back through precharge and bad supply
    a_ready_recover: assert property (@(posedge clock) disable iff (!resetn)
        s_sel_rise |-> !req_ready [*8])
        else $error("ready during precharge");
    a_ready_supply: assert property (@(posedge clock) disable iff (!resetn)
        req_ready |-> $past(supply_ok))
        else $error("ready with bad supply");
    a_addr_hold: assert property (@(posedge clock) disable iff (!resetn)
        s_sel_rise |-> $stable(mem_addr))
        else $error("address moved at select rise");
    // Strobe and gate stay inside their cycle kind
    a_strobe_in_select: assert property (@(posedge clock) disable iff (!resetn)
        !mem_wr_n |-> !mem_sel_n)
        else $error("write strobe outside select");
    a_gate_reads_only: assert property (@(posedge clock) disable iff (!resetn)
        !mem_oe_n |-> mem_wr_n && !bidir_data_bus_oe)
        else $error("output gate low on a write");
    a_response_read: assert property (@(posedge clock) disable iff (!resetn)
        rsp_valid |-> s_sel_rise)
        else $error("response without cycle end");
    a_rdata_holds: assert property (@(posedge clock) disable iff (!resetn)
        $changed(rsp_rdata) |-> rsp_valid)
        else $error("read data moved without response");
endmodule
`default_nettype wire

// file: verif/bnv_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Behavioural bytewide memory
// ****************************************
module bnv_mem_model (
    input wire logic sel_n,
    input wire logic wr_n,
    input wire logic oe_n,
    input wire logic [12:0] addr,
    input wire logic [7:0] din,
    output logic [7:0] dout,
    output logic drive
);
    logic [7:0] mem [0:8191];
    int wear [0:2047] = '{default: 0};
    int viol = 0;
    logic [12:0] lat = '0;
    logic is_wr = 1'b0;
    logic valid = 1'b0;
    logic in_cycle = 1'b0;
    realtime t_fall = 0.0;
    realtime t_rise = -1000.0;
    // Cycle start: latch address, wear row, check recovery
    always @(negedge sel_n) begin
        lat = addr;
        is_wr = !wr_n;
        wear[addr[12:2]]++;
        t_fall = $realtime;
        in_cycle = 1'b1;
        if (t_fall - t_rise < bnv_pkg::RECOVERY_NS) viol++;
    end
    // Data valid just inside the access time, no supply gating
    always @(negedge sel_n) begin
        valid = 1'b0;
        #(bnv_pkg::ACCESS_NS - 2);
        valid = !sel_n;
    end
    // Late strobe turns a read into a write
    always @(negedge wr_n) if (!sel_n) is_wr = 1'b1;
    // Strobe rising first ends the write
    always @(posedge wr_n) begin
        if (!sel_n && is_wr) mem[lat] = din;
        if (!sel_n) is_wr = 1'b0;
    end
    // Select rising ends the access and starts precharge
    always @(posedge sel_n) begin
        if (is_wr) mem[lat] = din;
        is_wr = 1'b0;
        valid = 1'b0;
        // Only a rise that closes a started cycle is timed
        if (in_cycle) begin
            t_rise = $realtime;
            if (t_rise - t_fall < bnv_pkg::SELECT_MIN_NS) viol++;
            if (t_rise - t_fall > bnv_pkg::SELECT_MAX_NS) viol++;
        end
        in_cycle = 1'b0;
    end
    // Bus driven only with gate low and data valid
    assign drive = valid && !oe_n && !is_wr;
    assign dout = mem[lat];
endmodule
`default_nettype wire

// file: verif/bnv_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Bench for the memory cycle controller
// ****************************************
module bnv_ctrl_tb_top;
    localparam int AW = bnv_pkg::ADDR_W;
    localparam int DW = bnv_pkg::DATA_W;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic supply_ok = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [AW-1:0] req_addr = '0;
    logic [DW-1:0] req_wdata = '0;
    logic req_ready, rsp_valid, sel_n, wr_n, oe_n, bus_oe, mem_drive;
    logic [DW-1:0] rsp_rdata, bus_o, mem_dout, bus, last = '0;
    logic [AW-1:0] mem_addr;
    logic [AW-1:0] addrs [12];
    logic [DW-1:0] shadow [logic [AW-1:0]];
    logic [DW:0] notes [$];
    logic [DW:0] note;
    int error_cnt = 0;
    int compares = 0;
    int wear0;
    // Clock
    always #(bnv_pkg::CLK_PERIOD_NS / 2) clock = ~clock;
    // Bus level; a released bus shows the inverse of its last value
    assign #1 bus = bus_oe ? bus_o : mem_drive ? mem_dout : ~last;
    always @(posedge clock) last <= bus;
    bnv_ctrl u_bnv_ctrl (.clock(clock), .resetn(resetn), .supply_ok(supply_ok),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .mem_sel_n(sel_n), .mem_wr_n(wr_n), .mem_oe_n(oe_n),
        .mem_addr(mem_addr), .bidir_data_bus_o(bus_o), .bidir_data_bus_oe(bus_oe),
        .bidir_data_bus_i(bus));
    bnv_mem_model u_bnv_mem_model (.sel_n(sel_n), .wr_n(wr_n), .oe_n(oe_n),
        .addr(mem_addr), .din(bus), .dout(mem_dout), .drive(mem_drive));
    // Compare and count
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Verdict and end of run
    task automatic wrap_up;
        if (error_cnt == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One request held until taken, expectation noted
    task automatic op(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d);
        int n;
        @(posedge clock);
        supply_ok <= 1'b1;
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (req_ready !== 1'b1 && n < 100);
        if (req_ready !== 1'b1) begin
            error_cnt++;
            wrap_up();
        end
        if (wr) shadow[a] = d;
        notes.push_back({!wr, shadow[a]});
        req_valid <= 1'b0;
    endtask
    // Bounded wait for all responses
    task automatic drain;
        for (int n = 0; notes.size() > 0; n++) begin
            if (n == 500) begin
                error_cnt++;
                wrap_up();
            end
            @(posedge clock);
        end
    endtask
    // Response monitor and bus clash watch
    always @(posedge clock) begin
        if (rsp_valid === 1'b1) begin
            note = notes.size() > 0 ? notes.pop_front() : '1;
            if (note[DW]) chk("rsp_rdata", 16'(rsp_rdata), 16'(note[DW-1:0]));
        end
        if (mem_drive && bus_oe) chk("bus clash", 16'h0001, 16'h0000);
    end
    // Hang guard
    initial begin
        repeat (30000) @(posedge clock);
        error_cnt++;
        wrap_up();
    end
    // Main sequence
    initial begin
        void'($urandom(69015));
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        foreach (addrs[i]) begin
            addrs[i] = AW'($urandom);
            op(1'b1, addrs[i], DW'($urandom));
        end
        foreach (addrs[i]) op(1'b0, addrs[i], '0);
        for (int i = 0; i < 2; i++) begin
            op(1'b1, i ? '1 : '0, DW'($urandom));
            op(1'b0, i ? '1 : '0, '0);
        end
        drain();
        wear0 = u_bnv_mem_model.wear[64];
        for (int i = 0; i < 4; i++) op(1'b1, AW'(256 + i), DW'(i));
        drain();
        chk("row wear", 16'(u_bnv_mem_model.wear[64] - wear0), 16'h0004);
        @(posedge clock);
        supply_ok <= 1'b0;
        req_valid <= 1'b1;
        req_write <= 1'b0;
        repeat (40) begin
            @(posedge clock);
            chk("select with bad supply", 16'(sel_n), 16'h0001);
        end
        chk("ready with bad supply", 16'(req_ready), 16'h0000);
        op(1'b0, addrs[0], '0);
        drain();
        chk("cycle timing faults", 16'(u_bnv_mem_model.viol), 16'h0000);
        wrap_up();
    end
endmodule
`default_nettype wire
